// ===== bench/sttt_comp_model.sv
`timescale 1ns/1ns
module sttt_comp_model
(
  // Sample clock
  input  wire logic          mclk,
  // Comparator bits towards the trigger block
  output sttt_pkg::sttt_cmp_t cmp
);
  // ------
  // Level and edge drivers
  // ------
  initial cmp = '0;
  // Fast edge: both thresholds cross in the same cycle
  task automatic set_ch(input int c, input logic v);
    @(posedge mclk);
    cmp.lo[c] <= v;
    cmp.hi[c] <= v;
  endtask
  // Slow edge: near threshold first, far one n cycles later
  task automatic ramp(input int c, input logic up, input int n);
    @(posedge mclk);
    if (up)
      cmp.lo[c] <= 1'b1;
    else
      cmp.hi[c] <= 1'b0;
    repeat (n) @(posedge mclk);
    cmp.hi[c] <= up;
    cmp.lo[c] <= up;
  endtask
endmodule

// ===== bench/sttt_trigger_sva.sv
`timescale 1ns/1ns
module sttt_trigger_sva
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        resetn,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Trigger outputs
  input wire logic        trig_pulse,
  input wire logic        irq
);
  // ------
  // Properties
  // ------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  a_pulse_single: assert property (trig_pulse |=> !trig_pulse)
    else $error("trigger pulse wider than one cycle");
  a_reset_quiet: assert property ($rose(resetn) |-> !trig_pulse && !irq)
    else $error("output active just after reset");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_refused_zero: assert property (s_axi_rvalid && s_axi_rresp == sttt_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  a_arready_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("read address ready held");
  // Main scenarios reached
  c_trigger: cover property (trig_pulse);
  c_irq: cover property ($rose(irq));
  c_refused: cover property (s_axi_bvalid && s_axi_bresp == sttt_pkg::RESP_SLVERR);
endmodule
bind sttt_trigger sttt_trigger_sva i_sva
(
  .mclk, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .trig_pulse, .irq
);

// ===== bench/tb.sv
`timescale 1ns/1ns
module tb;
  logic                mclk = 1'b0;
  logic                resetn = 1'b0;
  sttt_pkg::sttt_cmp_t cmp;
  logic [7:0]          awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]         wdata = 32'h0, rdata;
  logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                arvalid = 1'b0, rready = 1'b0;
  logic                awready, wready, bvalid, arready, rvalid, trig_pulse, irq;
  logic [1:0]          bresp, rresp;
  int                  bad_count = 0, checks = 0, pulses = 0, base = 0;
  // Edge table: cfg, direction, gap, pulses
  int                  tc [6] = '{7, 3, 3, 15, 7, 11};
  int                  tu [6] = '{1, 1, 1, 0, 0, 1};
  int                  tn [6] = '{8, 1, 8, 8, 8, 1};
  int                  te [6] = '{1, 1, 0, 1, 0, 0};
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  sttt_comp_model i_cmp (.mclk(mclk), .cmp(cmp));
  sttt_trigger i_dut
  (
    .mclk(mclk), .resetn(resetn), .cmp_in(cmp),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .trig_pulse(trig_pulse), .irq(irq)
  );
  // Counted at the edge, read only on the falling edge
  always @(posedge mclk)
    if (trig_pulse === 1'b1) pulses++;
  // ------
  // Checking and bus tasks
  // ------
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait used up: give up at once
  task automatic hung(input int n);
    if (n == 20)
    begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 20 && !bvalid; n++)
    begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    hung(n);
    chk(bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 20 && !rvalid; n++)
    begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    hung(n);
    chk(rdata, ed);
    chk(rresp, er);
  endtask
  // Pulses since the previous call must equal e
  task automatic run(input int cyc, input int e);
    repeat (cyc) @(negedge mclk);
    chk(pulses - base, e);
    base = pulses;
  endtask
  // ------
  // Main sequence
  // ------
  initial
  begin
    logic [1:0] ok;
    logic [1:0] er;
    ok = sttt_pkg::RESP_OKAY;
    er = sttt_pkg::RESP_SLVERR;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    rd(8'h0c, 32'h64, ok);
    rd(8'h14, 32'h64, ok);
    rd(8'h24, 32'h0, er);
    wr(8'h24, 32'h1, er);
    wr(8'h4c, 32'h7, ok);
    rd(8'h4c, 32'h7, ok);
    $display("end of test: registers");
    // Clock ch1, ch2 high, ch3 low, ch4 ignored
    i_cmp.set_ch(1, 1'b1);
    wr(8'h00, 32'h1, ok);
    for (int k = 0; k < 6; k++)
    begin
      i_cmp.set_ch(1, k != 5);
      wr(8'h04, 32'h40a00 | ((k / 3) << 2) | ((k % 3) << 3), ok);
      i_cmp.set_ch(0, 1'b1);
      repeat (6) @(posedge mclk);
      i_cmp.set_ch(0, 1'b0);
      run(10, (k % 3 == 2) ? 2 : (k < 3) ? 1 : 0);
    end
    wr(8'h04, 32'h40900, ok);
    rd(8'h20, 32'h1, ok);
    $display("end of test: state");
    wr(8'h0c, 32'h8, ok);
    for (int k = 0; k < 3; k++)
    begin
      wr(8'h00, 32'h0, ok);
      i_cmp.set_ch(2, k != 0);
      wr(8'h08, 32'h2 | (k << 2), ok);
      wr(8'h00, 32'h2, ok);
      i_cmp.set_ch(2, k != 1);
      run(25, 1);
    end
    $display("end of test: timeout");
    wr(8'h14, 32'h4, ok);
    for (int k = 0; k < 6; k++)
    begin
      wr(8'h00, 32'h0, ok);
      i_cmp.set_ch(3, !tu[k][0]);
      wr(8'h10, tc[k], ok);
      wr(8'h00, 32'h3, ok);
      i_cmp.ramp(3, tu[k][0], tn[k]);
      run(15, te[k]);
    end
    $display("end of test: transition");
    // Second set: high timeout on ch2, first set would fire at once
    wr(8'h48, 32'h1, ok);
    wr(8'h00, 32'h6, ok);
    run(20, 0);
    i_cmp.set_ch(1, 1'b1);
    run(20, 1);
    $display("end of test: stage select");
    rd(8'h18, 32'h7, ok);
    chk(irq, 1'b0);
    wr(8'h1c, 32'h2, ok);
    run(3, 0);
    chk(irq, 1'b1);
    wr(8'h18, 32'h2, ok);
    run(3, 0);
    chk(irq, 1'b0);
    rd(8'h18, 32'h5, ok);
    $display("end of test: interrupt");
    print_verdict();
  end
endmodule

// ===== logic/sttt_pkg.sv
package sttt_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATE    = 8'h04;
  localparam logic [7:0] OFF_TMO_CFG  = 8'h08;
  localparam logic [7:0] OFF_TMO_TIME = 8'h0c;
  localparam logic [7:0] OFF_TRN_CFG  = 8'h10;
  localparam logic [7:0] OFF_TRN_TIME = 8'h14;
  localparam logic [7:0] OFF_STATUS   = 8'h18;
  localparam logic [7:0] OFF_MASK     = 8'h1c;
  localparam logic [7:0] OFF_CONFLICT = 8'h20;
  localparam int         STAGE_STRIDE = 32'h0000_0040;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int          NUM_CH       = 4;
  localparam int          CTRL_MODE_LO = 0;
  localparam int          CTRL_STAGE   = 2;
  localparam int          ST_CLK_LO    = 0;
  localparam int          ST_SENSE     = 2;
  localparam int          ST_EDGE_LO   = 3;
  localparam int          ST_QUAL_LO   = 8;
  localparam int          QUAL_W       = 3;
  localparam int          TM_SRC_LO    = 0;
  localparam int          TM_COND_LO   = 2;
  localparam int          TR_SRC_LO    = 0;
  localparam int          TR_LONGER    = 2;
  localparam int          TR_FALL      = 3;
  localparam int          TR_LOW_LO    = 4;
  localparam int          TR_HIGH_LO   = 6;
  localparam int          STAT_W       = 3;
  localparam logic [31:0] TIME_RESET   = 32'h0000_0064;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  // ------------------------------------------------------------
  // Enumerations
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_OFF     = 2'b00,
    MODE_STATE   = 2'b01,
    MODE_TIMEOUT = 2'b10,
    MODE_TRANS   = 2'b11
  } sttt_mode_t;

  typedef enum logic [2:0] {
    QUAL_LOW          = 3'b000,
    QUAL_HIGH         = 3'b001,
    QUAL_IGNORE_LEVEL = 3'b010,
    QUAL_RISE         = 3'b011,
    QUAL_FALL         = 3'b100
  } sttt_qual_t;

  typedef enum logic [1:0] {
    EDGE_RISE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_BOTH = 2'b10
  } sttt_edge_t;

  typedef enum logic [1:0] {
    TMO_HIGH      = 2'b00,
    TMO_LOW       = 2'b01,
    TMO_NO_CHANGE = 2'b10
  } sttt_tmo_t;

  typedef enum logic [1:0] {
    TRN_IDLE = 2'b00,
    TRN_TIME = 2'b01,
    TRN_DONE = 2'b10
  } sttt_trn_state_t;

  // One stage's complete setting set
  typedef struct packed {
    logic [31:0] state_cfg;
    logic [31:0] tmo_cfg;
    logic [31:0] tmo_time;
    logic [31:0] trn_cfg;
    logic [31:0] trn_time;
  } sttt_stage_t;

  // Lower and upper comparator bits of each channel
  typedef struct packed {
    logic [NUM_CH-1:0] lo;
    logic [NUM_CH-1:0] hi;
  } sttt_cmp_t;

endpackage

// ===== logic/sttt_trigger.sv
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
// Summary of operation
// - State mode clock is one selectable channel, one through four.
// - Each channel holds a qualifier: low, high, ignore_level, rising or falling.
// - Flag a conflict when the clock channel has a non-ignore qualifier.
// - AND sense: trigger on clock edge when the whole pattern matches.
// - NAND sense: trigger on clock edge when the pattern does not match.
// - Pattern is evaluated on rising, falling or both clock edges.
// - Two independent setting sets, first_stage and second_stage, chosen by index.
// - Timeout high: trigger once channel stays high longer than the duration.
// - Timeout low: trigger once channel stays low longer than the duration.
// - Timeout no_change: trigger once channel holds any level longer than duration.
// - Timeout detector watches one channel, selectable one through four.
// - Elapsed level time is compared with a programmed duration.
// - Transition mode times edges between lower and upper threshold crossings.
// - longer_than flags slow edges, shorter_than flags fast edges.
// - rise_check examines rising edges only, fall_check falling edges only.
// - Transition limit is programmable; source is one channel of four.
module sttt_trigger
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              resetn,
  // Comparator inputs from the digitizer
  input  wire sttt_pkg::sttt_cmp_t cmp_in,
  // AXI4-Lite write address and data
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Trigger results
  output logic                   trig_pulse,
  output logic                   irq
);

  localparam int N = sttt_pkg::NUM_CH;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  sttt_pkg::sttt_cmp_t cmp_meta;
  sttt_pkg::sttt_cmp_t cmp_sync;
  sttt_pkg::sttt_cmp_t cmp_prev;

  // Two stages since the comparators are asynchronous to mclk
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      cmp_meta <= '0;
      cmp_sync <= '0;
      cmp_prev <= '0;
    end
    else
    begin
      cmp_meta <= cmp_in;
      cmp_sync <= cmp_meta;
      cmp_prev <= cmp_sync;
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic [31:0]        ctrl;
  sttt_pkg::sttt_stage_t stage [2];
  logic [sttt_pkg::STAT_W-1:0] status;
  logic [sttt_pkg::STAT_W-1:0] mask;
  logic [sttt_pkg::STAT_W-1:0] ev;

  // Active setting set, chosen by the stage index
  sttt_pkg::sttt_stage_t act;
  sttt_pkg::sttt_mode_t  mode;
  assign act  = stage[ctrl[sttt_pkg::CTRL_STAGE]];
  assign mode = sttt_pkg::sttt_mode_t'(ctrl[sttt_pkg::CTRL_MODE_LO +: 2]);

  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  logic [7:0]  aw_q;
  logic [31:0] w_q;
  logic [3:0]  ws_q;
  logic        aw_have;
  logic        w_have;
  logic        do_write;
  logic        wr_ok;
  logic [7:0]  wr_off;
  logic        wr_stg;

  assign do_write = aw_have && w_have && !s_axi_bvalid;
  assign wr_stg   = aw_q[6];
  assign wr_off   = {2'b00, aw_q[5:0]};

  // Address and data are taken in either order, then answered
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      aw_q          <= '0;
      w_q           <= '0;
      ws_q          <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= sttt_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_have && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have <= 1'b1;
        aw_q    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have <= 1'b1;
        w_q    <= s_axi_wdata;
        ws_q   <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? sttt_pkg::RESP_OKAY : sttt_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Decode of writable words; unmapped offsets answer SLVERR
  always_comb
  begin
    wr_ok = 1'b0;
    if (aw_q[7] == 1'b0)
    begin
      if (aw_q[6])
        wr_ok = wr_off inside {sttt_pkg::OFF_STATE, sttt_pkg::OFF_TMO_CFG,
                               sttt_pkg::OFF_TMO_TIME, sttt_pkg::OFF_TRN_CFG,
                               sttt_pkg::OFF_TRN_TIME};
      else
        wr_ok = wr_off inside {sttt_pkg::OFF_CTRL, sttt_pkg::OFF_STATE,
                               sttt_pkg::OFF_TMO_CFG, sttt_pkg::OFF_TMO_TIME,
                               sttt_pkg::OFF_TRN_CFG, sttt_pkg::OFF_TRN_TIME,
                               sttt_pkg::OFF_STATUS, sttt_pkg::OFF_MASK};
    end
  end

  // Byte-lane merge of the staged write data
  function automatic logic [31:0] merge(input logic [31:0] old_v);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
      if (ws_q[b])
        r[8*b +: 8] = w_q[8*b +: 8];
    return r;
  endfunction

  // Control and both stage setting sets
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      ctrl <= '0;
      mask <= '0;
      for (int s = 0; s < 2; s++)
      begin
        stage[s].state_cfg <= 32'h0000_0000;
        stage[s].tmo_cfg   <= 32'h0000_0000;
        stage[s].tmo_time  <= sttt_pkg::TIME_RESET;
        stage[s].trn_cfg   <= 32'h0000_0000;
        stage[s].trn_time  <= sttt_pkg::TIME_RESET;
      end
    end
    else if (do_write && wr_ok)
    begin
      case (wr_off)
        sttt_pkg::OFF_CTRL:     ctrl <= merge(ctrl);
        sttt_pkg::OFF_MASK:     mask <= sttt_pkg::STAT_W'(merge(32'(mask)));
        sttt_pkg::OFF_STATE:    stage[wr_stg].state_cfg <= merge(stage[wr_stg].state_cfg);
        sttt_pkg::OFF_TMO_CFG:  stage[wr_stg].tmo_cfg   <= merge(stage[wr_stg].tmo_cfg);
        sttt_pkg::OFF_TMO_TIME: stage[wr_stg].tmo_time  <= merge(stage[wr_stg].tmo_time);
        sttt_pkg::OFF_TRN_CFG:  stage[wr_stg].trn_cfg   <= merge(stage[wr_stg].trn_cfg);
        sttt_pkg::OFF_TRN_TIME: stage[wr_stg].trn_time  <= merge(stage[wr_stg].trn_time);
        default:                ctrl <= ctrl;
      endcase
    end
  end

  // ------------------------------------------------------------
  // State mode
  // ------------------------------------------------------------
  logic [1:0] clk_sel;
  logic       clk_rise;
  logic       clk_fall;
  logic       clk_edge;
  logic [N-1:0] ch_ok;
  logic [N-1:0] ch_conf;
  logic       pat_match;
  logic       state_hit;
  sttt_pkg::sttt_edge_t edge_sel;

  assign clk_sel  = act.state_cfg[sttt_pkg::ST_CLK_LO +: 2];
  assign edge_sel = sttt_pkg::sttt_edge_t'(act.state_cfg[sttt_pkg::ST_EDGE_LO +: 2]);
  assign clk_rise = cmp_sync.hi[clk_sel] && !cmp_prev.hi[clk_sel];
  assign clk_fall = !cmp_sync.hi[clk_sel] && cmp_prev.hi[clk_sel];

  // Clock edge qualifier; unknown codes never fire
  always_comb
  begin
    case (edge_sel)
      sttt_pkg::EDGE_RISE: clk_edge = clk_rise;
      sttt_pkg::EDGE_FALL: clk_edge = clk_fall;
      sttt_pkg::EDGE_BOTH: clk_edge = clk_rise || clk_fall;
      default:             clk_edge = 1'b0;
    endcase
  end

  // Per-channel pattern term; the clock channel takes no part
  for (genvar c = 0; c < N; c++)
  begin : g_pat
    sttt_pkg::sttt_qual_t q;
    logic now_v;
    logic was_v;
    logic ok_v;
    assign q     = sttt_pkg::sttt_qual_t'(act.state_cfg[sttt_pkg::ST_QUAL_LO
                                                         + sttt_pkg::QUAL_W*c +: 3]);
    assign now_v = cmp_sync.hi[c];
    assign was_v = cmp_prev.hi[c];
    assign ch_conf[c] = (clk_sel == 2'(c)) && (q != sttt_pkg::QUAL_IGNORE_LEVEL);
    // Local term keeps each process the only writer of its variable
    always_comb
    begin
      case (q)
        sttt_pkg::QUAL_LOW:          ok_v = !now_v;
        sttt_pkg::QUAL_HIGH:         ok_v = now_v;
        sttt_pkg::QUAL_IGNORE_LEVEL: ok_v = 1'b1;
        sttt_pkg::QUAL_RISE:         ok_v = now_v && !was_v;
        sttt_pkg::QUAL_FALL:         ok_v = !now_v && was_v;
        default:                     ok_v = 1'b0;
      endcase
      if (clk_sel == 2'(c))
        ok_v = 1'b1;
    end
    assign ch_ok[c] = ok_v;
  end

  assign pat_match = &ch_ok;
  // Sense bit low is AND, high is NAND
  assign state_hit = clk_edge && (act.state_cfg[sttt_pkg::ST_SENSE] ? !pat_match
                                                                   : pat_match);

  // ------------------------------------------------------------
  // Timeout mode
  // ------------------------------------------------------------
  logic [1:0]  tm_src;
  logic        tm_lvl;
  logic        tm_prev_lvl;
  logic [31:0] tm_cnt;
  logic        tm_fired;
  logic        tm_qual;
  logic        tm_hit;
  sttt_pkg::sttt_tmo_t tm_cond;

  assign tm_src      = act.tmo_cfg[sttt_pkg::TM_SRC_LO +: 2];
  assign tm_cond     = sttt_pkg::sttt_tmo_t'(act.tmo_cfg[sttt_pkg::TM_COND_LO +: 2]);
  assign tm_lvl      = cmp_sync.hi[tm_src];
  assign tm_prev_lvl = cmp_prev.hi[tm_src];

  // Level that keeps the timer running
  always_comb
  begin
    case (tm_cond)
      sttt_pkg::TMO_HIGH:      tm_qual = tm_lvl;
      sttt_pkg::TMO_LOW:       tm_qual = !tm_lvl;
      sttt_pkg::TMO_NO_CHANGE: tm_qual = (tm_lvl == tm_prev_lvl);
      default:                 tm_qual = 1'b0;
    endcase
  end

  // Fires once per stretch, when the count reaches the duration
  assign tm_hit = (mode == sttt_pkg::MODE_TIMEOUT) && tm_qual && !tm_fired
                  && (tm_cnt >= act.tmo_time);

  // Elapsed cycles at a constant level, saturating
  always_ff @(posedge mclk)
  begin
    if (!resetn || mode != sttt_pkg::MODE_TIMEOUT || !tm_qual)
    begin
      tm_cnt   <= '0;
      tm_fired <= 1'b0;
    end
    else
    begin
      if (tm_cnt != 32'hffff_ffff)
        tm_cnt <= tm_cnt + 32'h0000_0001;
      if (tm_hit)
        tm_fired <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Transition mode
  // ------------------------------------------------------------
  logic [1:0]  tr_src;
  logic        tr_fall_sel;
  logic        tr_start;
  logic        tr_end;
  logic        tr_abort;
  logic [31:0] tr_cnt;
  logic        tr_hit;
  sttt_pkg::sttt_trn_state_t tr_state;

  assign tr_src      = act.trn_cfg[sttt_pkg::TR_SRC_LO +: 2];
  assign tr_fall_sel = act.trn_cfg[sttt_pkg::TR_FALL];
  // Rising: leaves the lower level, reaches the upper one; falling mirrored
  assign tr_start = tr_fall_sel ? (!cmp_sync.hi[tr_src] && cmp_prev.hi[tr_src])
                                : (cmp_sync.lo[tr_src] && !cmp_prev.lo[tr_src]);
  assign tr_end   = tr_fall_sel ? (!cmp_sync.lo[tr_src] && cmp_prev.lo[tr_src])
                                : (cmp_sync.hi[tr_src] && !cmp_prev.hi[tr_src]);
  // Edge turned back across its starting threshold
  assign tr_abort = tr_fall_sel ? cmp_sync.hi[tr_src] : !cmp_sync.lo[tr_src];

  // Edge timer between the two threshold crossings
  always_ff @(posedge mclk)
  begin
    if (!resetn || mode != sttt_pkg::MODE_TRANS)
    begin
      tr_state <= sttt_pkg::TRN_IDLE;
      tr_cnt   <= '0;
      tr_hit   <= 1'b0;
    end
    else
    begin
      tr_hit <= 1'b0;
      case (tr_state)
        sttt_pkg::TRN_IDLE:
        begin
          tr_cnt <= 32'h0000_0001;
          if (tr_start && tr_end)
            tr_hit <= !act.trn_cfg[sttt_pkg::TR_LONGER];
          else if (tr_start)
            tr_state <= sttt_pkg::TRN_TIME;
        end
        sttt_pkg::TRN_TIME:
        begin
          if (tr_cnt != 32'hffff_ffff)
            tr_cnt <= tr_cnt + 32'h0000_0001;
          if (tr_end)
          begin
            // Slow edges already fired at the limit below
            tr_hit   <= !act.trn_cfg[sttt_pkg::TR_LONGER] && (tr_cnt < act.trn_time);
            tr_state <= sttt_pkg::TRN_IDLE;
          end
          else if (tr_abort)
            tr_state <= sttt_pkg::TRN_IDLE;
          else if (act.trn_cfg[sttt_pkg::TR_LONGER] && tr_cnt == act.trn_time)
          begin
            tr_hit   <= 1'b1;
            tr_state <= sttt_pkg::TRN_DONE;
          end
        end
        sttt_pkg::TRN_DONE:
          if (tr_end || tr_abort)
            tr_state <= sttt_pkg::TRN_IDLE;
        default:
          tr_state <= sttt_pkg::TRN_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Trigger output, status and interrupt
  // ------------------------------------------------------------
  assign ev = {tr_hit, tm_hit, (mode == sttt_pkg::MODE_STATE) && state_hit};

  // Single-cycle trigger pulse
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      trig_pulse <= 1'b0;
    else
      trig_pulse <= |ev;
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      status <= '0;
    else if (do_write && wr_ok && wr_off == sttt_pkg::OFF_STATUS && ws_q[0])
      status <= (status & ~w_q[sttt_pkg::STAT_W-1:0]) | ev;
    else
      status <= status | ev;
  end

  // Level interrupt from unmasked status
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= |(status & mask);
  end

  // ------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------
  logic [31:0] rd_val;
  logic        rd_ok;
  logic [7:0]  rd_off;
  sttt_pkg::sttt_stage_t rs;

  assign rd_off = {2'b00, s_axi_araddr[5:0]};
  assign rs     = stage[s_axi_araddr[6]];

  // Read decode; conflict word shows state of the active stage, not the addressed one
  always_comb
  begin
    rd_val = '0;
    rd_ok  = !s_axi_araddr[7];
    case (rd_off)
      sttt_pkg::OFF_CTRL:     rd_val = ctrl;
      sttt_pkg::OFF_STATE:    rd_val = rs.state_cfg;
      sttt_pkg::OFF_TMO_CFG:  rd_val = rs.tmo_cfg;
      sttt_pkg::OFF_TMO_TIME: rd_val = rs.tmo_time;
      sttt_pkg::OFF_TRN_CFG:  rd_val = rs.trn_cfg;
      sttt_pkg::OFF_TRN_TIME: rd_val = rs.trn_time;
      sttt_pkg::OFF_STATUS:   rd_val = 32'(status);
      sttt_pkg::OFF_MASK:     rd_val = 32'(mask);
      sttt_pkg::OFF_CONFLICT: rd_val = {31'h0000_0000, |ch_conf};
      default:                rd_ok  = 1'b0;
    endcase
  end

  // One read at a time, answered the cycle after the address is taken
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= sttt_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_ok ? rd_val : 32'h0000_0000;
        s_axi_rresp  <= rd_ok ? sttt_pkg::RESP_OKAY : sttt_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule
